// [src/dcs_defs.svh]
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
// Register byte offsets
`define DCS_OFF_STATUS 12'h000
`define DCS_OFF_CTRL 12'h004
// Status field positions
`define DCS_BIT_ACTIVE 10
`define DCS_BIT_EOT 9
`define DCS_BIT_EOC 8
`define DCS_BIT_MEMF 6
`define DCS_BIT_LBF 5
// Control field positions
`define DCS_BIT_START 0
`define DCS_BIT_IEN 1
// Reset values
`define DCS_RST_STATUS 32'h0000_0000
`define DCS_RST_CTRL 32'h0000_0000
`endif

// [src/dcs_pkg.sv]
package dcs_pkg;
    typedef enum logic [1:0] {
        DCS_IDLE,
        DCS_BUSY
    } dcs_state_t;

    // Events reported by the transfer engine, one-cycle pulses
    typedef struct packed {
        logic done;
        logic last;
        logic master_abort;
        logic target_abort;
        logic parity_err;
        logic bus_fault;
    } dcs_evt_t;

    typedef struct packed {
        logic active;
        logic eot;
        logic eoc;
        logic memf;
        logic lbf;
    } dcs_flags_t;
endpackage

// [src/dcs_status.sv]
// How it works
// - Active flag bit 10 stays set while channel performs transfers.
// - Active flag reads clear when idle; channel may be reconfigured.
// - Active clears when count reaches zero on last chain descriptor.
// - A PCI master-abort ends the transfer and clears active.
// - A PCI target-abort ends the transfer and clears active.
// - A local memory parity error ends the transfer and clears active.
// - Bit 9 sets when interrupting after error-free non-last descriptor.
// - Bit 8 sets when interrupting after error-free last descriptor.
// - Bit 6 sets on parity error reading data or descriptors.
// - Bit 5 sets on local bus fault during data or descriptor access.
`timescale 1ns/1ps
`include "dcs_defs.svh"

module dcs_status
    import dcs_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire dcs_evt_t I_EVT,
    output logic O_START,
    output logic O_ACTIVE,
    output logic O_IRQ
);
    dcs_state_t state_q, state_d;
    dcs_flags_t flags_q, flags_d;
    logic ien_q, ien_d;
    logic start_q, start_d;
    logic irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic wr_acc, rd_setup, hit_status, hit_ctrl, err_end, ok_end;
    logic [31:0] w1c;

    assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
    // Read data is captured in the setup cycle so the access phase sees a flop
    assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign hit_status = (I_PADDR == `DCS_OFF_STATUS);
    assign hit_ctrl = (I_PADDR == `DCS_OFF_CTRL);
    assign err_end = I_EVT.master_abort || I_EVT.target_abort || I_EVT.parity_err
                     || I_EVT.bus_fault;
    assign ok_end = I_EVT.done && !err_end;
    // Write-one-to-clear mask; only lane 1 and lane 0 hold flags
    assign w1c = (wr_acc && hit_status)
        ? {16'h0000, I_PWDATA[15:8] & {8{I_PSTRB[1]}}, I_PWDATA[7:0] & {8{I_PSTRB[0]}}}
        : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        flags_d = flags_q;
        ien_d = ien_q;
        start_d = 1'b0;
        irq_d = 1'b0;
        prdata_d = prdata_q;
        if (wr_acc && hit_ctrl && I_PSTRB[0]) begin
            ien_d = I_PWDATA[`DCS_BIT_IEN];
        end
        // Software clears first so a same-cycle hardware event still wins
        if (w1c[`DCS_BIT_EOT]) flags_d.eot = 1'b0;
        if (w1c[`DCS_BIT_EOC]) flags_d.eoc = 1'b0;
        if (w1c[`DCS_BIT_MEMF]) flags_d.memf = 1'b0;
        if (w1c[`DCS_BIT_LBF]) flags_d.lbf = 1'b0;
        // Fault flags record even while idle, e.g. a stray descriptor fetch
        if (I_EVT.parity_err) flags_d.memf = 1'b1;
        if (I_EVT.bus_fault) flags_d.lbf = 1'b1;
        case (state_q)
            DCS_IDLE: begin
                // Start only honoured while idle
                if (wr_acc && hit_ctrl && I_PSTRB[0] && I_PWDATA[`DCS_BIT_START]) begin
                    state_d = DCS_BUSY;
                    start_d = 1'b1;
                end
            end
            DCS_BUSY: begin
                if (err_end) begin
                    // Errors take priority over a coincident completion
                    state_d = DCS_IDLE;
                end else if (ok_end) begin
                    if (I_EVT.last) begin
                        state_d = DCS_IDLE;
                        flags_d.eoc = 1'b1;
                    end else begin
                        flags_d.eot = 1'b1;
                    end
                    irq_d = ien_q;
                end
            end
            default: begin
                state_d = DCS_IDLE;
            end
        endcase
        flags_d.active = (state_d == DCS_BUSY);
        // Limitation: a flag that changes during the access phase shows next read
        if (rd_setup) begin
            prdata_d = 32'h0000_0000;
            if (hit_status) begin
                prdata_d[`DCS_BIT_ACTIVE] = flags_q.active;
                prdata_d[`DCS_BIT_EOT] = flags_q.eot;
                prdata_d[`DCS_BIT_EOC] = flags_q.eoc;
                prdata_d[`DCS_BIT_MEMF] = flags_q.memf;
                prdata_d[`DCS_BIT_LBF] = flags_q.lbf;
            end else if (hit_ctrl) begin
                prdata_d[`DCS_BIT_IEN] = ien_q;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state_q <= DCS_IDLE;
            flags_q <= '0;
            ien_q <= 1'b0;
            start_q <= 1'b0;
            irq_q <= 1'b0;
            prdata_q <= `DCS_RST_STATUS;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            ien_q <= ien_d;
            start_q <= start_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
        end
    end

    // Zero wait states; data was registered one cycle earlier in setup
    assign O_PREADY = 1'b1;
    assign O_PRDATA = prdata_q;
    assign O_PSLVERR = (I_PSEL && I_PENABLE) && !(hit_status || hit_ctrl);
    assign O_START = start_q;
    assign O_ACTIVE = flags_q.active;
    assign O_IRQ = irq_q;
endmodule // dcs_status

// [test/dcs_eng_model.sv]
`timescale 1ns/1ps
module dcs_eng_model
    import dcs_pkg::*;
(
    input wire logic i_clk,
    input wire logic [5:0] i_cmd,
    output dcs_evt_t o_evt
);
    // Registered so every event is a clean one-cycle pulse
    always_ff @(posedge i_clk) o_evt <= dcs_evt_t'(i_cmd);
endmodule // dcs_eng_model

// [test/dcs_status_monitor.sv]
`timescale 1ns/1ps
module dcs_status_monitor
    import dcs_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire dcs_evt_t I_EVT,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_START,
    input wire logic O_ACTIVE,
    input wire logic O_IRQ
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    property p_hold; O_ACTIVE && I_EVT == 6'h0 |=> O_ACTIVE; endproperty
    a_hold: assert property (p_hold) else $error("active dropped");
    property p_rise; $rose(O_ACTIVE) |-> O_START; endproperty
    a_rise: assert property (p_rise) else $error("active without start");
    property p_eoc; O_ACTIVE && I_EVT == 6'h30 |=> !O_ACTIVE; endproperty
    a_eoc: assert property (p_eoc) else $error("chain end kept active");
    property p_ma; O_ACTIVE && I_EVT.master_abort |=> !O_ACTIVE && !O_IRQ; endproperty
    a_ma: assert property (p_ma) else $error("master abort");
    property p_ta; O_ACTIVE && I_EVT.target_abort |=> !O_ACTIVE && !O_IRQ; endproperty
    a_ta: assert property (p_ta) else $error("target abort");
    property p_irq; O_IRQ |-> $past(I_EVT.done) && $past(I_EVT[3:0]) == 4'h0; endproperty
    a_irq: assert property (p_irq) else $error("bad irq");
    property p_memf;
        I_EVT.parity_err ##2 (I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == 12'h000)
            |-> O_PRDATA[6];
    endproperty
    a_memf: assert property (p_memf) else $error("memf not set");
    property p_lbf;
        I_EVT.bus_fault ##2 (I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == 12'h000)
            |-> O_PRDATA[5];
    endproperty
    a_lbf: assert property (p_lbf) else $error("lbf not set");
    property p_pe; O_ACTIVE && I_EVT.parity_err |=> !O_ACTIVE && !O_IRQ; endproperty
    a_pe: assert property (p_pe) else $error("parity kept active");
    property p_zero; I_PSEL && !I_PWRITE |-> O_PRDATA[31:11] == 21'h0; endproperty
    a_zero: assert property (p_zero) else $error("upper bits set");
endmodule // dcs_status_monitor
bind dcs_status dcs_status_monitor dcs_status_monitor_inst(.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_EVT(I_EVT),
    .O_PRDATA(O_PRDATA), .O_START(O_START), .O_ACTIVE(O_ACTIVE), .O_IRQ(O_IRQ));

// [test/tb_dcs_status.sv]
`timescale 1ns/1ps
module tb_dcs_status;
    import dcs_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, rdy, err, st, act, irq;
    logic [11:0] pa = 12'h000;
    logic [31:0] wd = 32'h0, rd, r;
    logic [5:0] cmd = 6'h0;
    dcs_evt_t evt;
    int failures = 0, cmp_count = 0, irqs = 0, starts = 0;
    logic se;
    dcs_status dcs_status_inst(.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd), .I_PSTRB(4'hf), .O_PRDATA(rd),
        .O_PREADY(rdy), .O_PSLVERR(err), .I_EVT(evt), .O_START(st), .O_ACTIVE(act),
        .O_IRQ(irq));
    dcs_eng_model dcs_eng_model_inst(.i_clk(clk), .i_cmd(cmd), .o_evt(evt));
    initial forever #4 clk = ~clk;
    // Pulse outputs stand one cycle; count them at every edge
    always @(posedge clk) begin
        if (irq === 1'b1) irqs++;
        if (st === 1'b1) starts++;
    end
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pw, pa, wd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        r = rd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic ev(input logic [5:0] c);
        @(posedge clk) cmd <= c;
        @(posedge clk) cmd <= 6'h0;
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        xf(0, 12'h000, 0); ck(r, 32'h0);
        xf(1, 12'h004, 32'h3);
        xf(0, 12'h000, 0); ck(r, 32'h400);
        xf(1, 12'h004, 32'h3); ck(starts, 1);
        xf(0, 12'h004, 0); ck(r, 32'h2);
        ev(6'h20);
        xf(0, 12'h000, 0); ck(r, 32'h600);
        ck(irqs, 1);
        ev(6'h30);
        xf(0, 12'h000, 0); ck(r, 32'h300);
        ck(irqs, 2);
        xf(1, 12'h000, 32'h300);
        xf(0, 12'h000, 0); ck(r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xf(1, 12'h004, 32'h3);
            ev(6'(1 << i));
            xf(0, 12'h000, 0); ck(r, i == 0 ? 32'h20 : i == 1 ? 32'h40 : 32'h0);
            xf(1, 12'h000, 32'h60);
        end
        ck(irqs, 2);
        ck(starts, 5);
        xf(0, 12'h008, 0); ck(r, 32'h0);
        ck(se, 1);
        xf(0, 12'h000, 0); ck(se, 0);
        summarize();
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule // tb_dcs_status
